// ==== prs_ctrl.sv ====
// page selector, soft reset, sleep/supply/broadcast control and shutdown policy
// assumes register strobes and all pins synchronous to sys_clk, one access per cycle
`timescale 1ns/100ps
`default_nettype none
// How it works
// - eight-bit page selector steers later accesses
// - soft reset write restores register defaults
// - soft reset bit clears itself afterwards
// - sleep while sleep bit low, run high
// - broadcast off: address from strap pins
// - broadcast on: fixed 1001100 (4Ch) target address
// - reference charge 3.5/10/50/100 ms by code
// - input charge 2.5/12.5/25/50 ms by code
// - policy 0: regulator off at once
// - policy 1: hold, forced off at timeout
// - policy 2: hold until clean shutdown done
// - keep-alive 30/25/10/5 ms by code
// - supply bit picks external or on-chip rail
// - shutdown config resets to 05h
module prs_ctrl
  import prs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  output logic      [7:0] page_select,
  input  wire logic [1:0] addr_strap_pin,
  output logic      [6:0] i2c_target_addr,
  output logic            sleep_active,
  output logic            analog_supply_source_sel,
  output logic            vref_fast_charge,
  output logic            input_cap_fast_charge,
  input  wire logic       shutdown_pin_n,
  input  wire logic       shutdown_done,
  output logic            core_regulator_en,
  output logic            shutdown_request
);

  typedef struct packed {
    logic [7:0]            page;
    logic                  srst_pend;
    logic [7:0]            sleep_cfg;
    logic [7:0]            shutdown_config;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic                  tick;
    logic                  sleep_q;
    logic                  pin_q;
    logic                  ka_busy_q;
    logic                  strap_done;
    logic [1:0]            strap;
    prs_reg_state_type     reg_state;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic [6:0]            i2c_addr;
    logic                  sleep_out;
    logic                  supply_out;
    logic                  vref_out;
    logic                  incap_out;
    logic                  reg_en_out;
    logic                  shut_req_out;
  } prs_ctrl_state_type;

  prs_ctrl_state_type st;
  prs_ctrl_state_type next_st;

  prs_timer_if vref_tmr ();
  prs_timer_if incap_tmr ();
  prs_timer_if ka_tmr ();

  // ****************************************************************
  // decode and events
  // ****************************************************************
  logic       page0_hit;
  logic       wr_page;
  logic       wr_srst;
  logic       wr_sleep;
  logic       wr_shdn;
  logic       sleep_rise;
  logic       pin_fall;
  logic       ka_done;
  logic [1:0] policy;

  // page_select is always reachable, the rest only on page 0
  assign page0_hit  = (st.page == PAGE_ZERO);
  assign wr_page    = reg_wr_en && (reg_addr == OFF_PAGE);
  assign wr_srst    = reg_wr_en && page0_hit && (reg_addr == OFF_SRST);
  assign wr_sleep   = reg_wr_en && page0_hit && (reg_addr == OFF_SLEEP);
  assign wr_shdn    = reg_wr_en && page0_hit && (reg_addr == OFF_SHDN);
  assign sleep_rise = st.sleep_cfg[SLEEP_BIT] && !st.sleep_q;
  assign pin_fall   = st.pin_q && !shutdown_pin_n;
  assign ka_done    = st.ka_busy_q && !ka_tmr.busy;
  assign policy     = st.shutdown_config[POLICY_LSB +: 2];

  // ****************************************************************
  // timers
  // ****************************************************************
  // both fast charges start when the device leaves sleep
  assign vref_tmr.tick        = st.tick;
  assign vref_tmr.start       = sleep_rise;
  assign vref_tmr.clear       = st.srst_pend || !st.sleep_cfg[SLEEP_BIT];
  assign vref_tmr.load_ticks  = pick_ticks(st.sleep_cfg[VREF_LSB +: 2], VREF_US_0,
                                           VREF_US_1, VREF_US_2, VREF_US_3);
  assign incap_tmr.tick       = st.tick;
  assign incap_tmr.start      = sleep_rise;
  assign incap_tmr.clear      = st.srst_pend || !st.sleep_cfg[SLEEP_BIT];
  assign incap_tmr.load_ticks = pick_ticks(st.shutdown_config[INCAP_LSB +: 2], INCAP_US_0,
                                           INCAP_US_1, INCAP_US_2, INCAP_US_3);
  // keep-alive runs from the shutdown edge under the timed policy
  assign ka_tmr.tick          = st.tick;
  assign ka_tmr.start         = (st.reg_state == PRS_REG_ON) && pin_fall
                                && (policy != POL_IMMEDIATE) && (policy != POL_UNTIL_DONE);
  assign ka_tmr.clear         = shutdown_pin_n;
  assign ka_tmr.load_ticks    = pick_ticks(st.shutdown_config[KA_LSB +: 2], KA_US_0,
                                           KA_US_1, KA_US_2, KA_US_3);

  prs_interval_timer u_vref_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tmr     (vref_tmr.timer)
  );

  prs_interval_timer u_incap_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tmr     (incap_tmr.timer)
  );

  prs_interval_timer u_ka_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tmr     (ka_tmr.timer)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;

    // 0.5 ms tick divider
    next_st.tick = 1'b0;
    if (st.tick_cnt >= TICK_CNT_W'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + TICK_CNT_W'(1);
    end

    // register writes; a pending soft reset wins over them
    if (st.srst_pend) begin
      next_st.page      = RST_PAGE;
      next_st.sleep_cfg = RST_SLEEP;
      next_st.shutdown_config  = RST_SHDN;
      next_st.srst_pend = 1'b0;
    end else begin
      if (wr_page) begin
        next_st.page = reg_wdata;
      end
      if (wr_srst) begin
        next_st.srst_pend = reg_wdata[SRST_BIT];
      end
      if (wr_sleep) begin
        next_st.sleep_cfg = reg_wdata & SLEEP_WMASK;
      end
      if (wr_shdn) begin
        next_st.shutdown_config = reg_wdata & SHDN_WMASK;
      end
    end

    // register reads, answered one cycle later
    next_st.rvalid = reg_rd_en;
    if (reg_rd_en) begin
      next_st.rdata = 8'h00;
      if (reg_addr == OFF_PAGE) begin
        next_st.rdata = st.page;
      end else if (page0_hit && reg_addr == OFF_SRST) begin
        next_st.rdata = {7'h00, st.srst_pend};
      end else if (page0_hit && reg_addr == OFF_SLEEP) begin
        next_st.rdata = st.sleep_cfg;
      end else if (page0_hit && reg_addr == OFF_SHDN) begin
        next_st.rdata = st.shutdown_config;
      end
    end

    // straps caught once, at the first edge after reset release
    if (!st.strap_done) begin
      next_st.strap      = addr_strap_pin;
      next_st.strap_done = 1'b1;
    end

    // target address selection
    if (st.sleep_cfg[BCAST_BIT]) begin
      next_st.i2c_addr = BCAST_ADDR;
    end else begin
      next_st.i2c_addr = {STRAP_BASE_ADDR[6:2], st.strap};
    end

    // edge history
    next_st.sleep_q   = st.sleep_cfg[SLEEP_BIT];
    next_st.pin_q     = shutdown_pin_n;
    next_st.ka_busy_q = ka_tmr.busy;

    // digital regulator shutdown policy
    case (st.reg_state)
      PRS_REG_ON: begin
        if (pin_fall) begin
          if (policy == POL_IMMEDIATE) begin
            next_st.reg_state = PRS_REG_OFF;
          end else begin
            next_st.reg_state = PRS_REG_HOLD;
          end
        end
      end
      PRS_REG_HOLD: begin
        if (shutdown_pin_n) begin
          next_st.reg_state = PRS_REG_ON;
        end else if (shutdown_done) begin
          next_st.reg_state = PRS_REG_OFF;
        end else if (ka_done && policy != POL_UNTIL_DONE) begin
          next_st.reg_state = PRS_REG_OFF;
        end
      end
      PRS_REG_OFF: begin
        if (shutdown_pin_n) begin
          next_st.reg_state = PRS_REG_ON;
        end
      end
      default: begin
        next_st.reg_state = PRS_REG_ON;
      end
    endcase

    // registered outputs
    next_st.sleep_out    = !st.sleep_cfg[SLEEP_BIT];
    next_st.supply_out   = st.sleep_cfg[SUPPLY_BIT];
    next_st.vref_out     = vref_tmr.busy;
    next_st.incap_out    = incap_tmr.busy;
    next_st.reg_en_out   = (next_st.reg_state != PRS_REG_OFF);
    next_st.shut_req_out = (next_st.reg_state == PRS_REG_HOLD);
  end

  // state register; power-on values
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st            <= '0;
      st.page       <= RST_PAGE;
      st.sleep_cfg  <= RST_SLEEP;
      st.shutdown_config   <= RST_SHDN;
      st.pin_q      <= 1'b1;
      st.reg_state  <= PRS_REG_ON;
      st.i2c_addr   <= STRAP_BASE_ADDR;
      st.sleep_out  <= 1'b1;
      st.reg_en_out <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata                = st.rdata;
  assign reg_rd_valid             = st.rvalid;
  assign page_select              = st.page;
  assign i2c_target_addr          = st.i2c_addr;
  assign sleep_active             = st.sleep_out;
  assign analog_supply_source_sel = st.supply_out;
  assign vref_fast_charge         = st.vref_out;
  assign input_cap_fast_charge    = st.incap_out;
  assign core_regulator_en        = st.reg_en_out;
  assign shutdown_request         = st.shut_req_out;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence srst_seq;
    st.srst_pend ##1 (!st.srst_pend && st.page == RST_PAGE && st.sleep_cfg == RST_SLEEP
                      && st.shutdown_config == RST_SHDN);
  endsequence

  page_write_a: assert property (wr_page && !st.srst_pend |=> st.page == $past(reg_wdata))
    else $error("page select not written");

  srst_restore_a: assert property (wr_srst && reg_wdata[SRST_BIT] && !st.srst_pend
                                   |=> srst_seq)
    else $error("soft reset did not restore defaults");

  srst_selfclr_a: assert property (st.srst_pend |=> !st.srst_pend)
    else $error("soft reset bit did not self clear");

  sleep_exit_a: assert property (wr_sleep && reg_wdata[SLEEP_BIT] && !st.srst_pend
                                 |=> ##1 !sleep_active)
    else $error("device stayed asleep");

  strap_addr_a: assert property (st.strap_done && !st.sleep_cfg[BCAST_BIT]
                                 |=> i2c_target_addr[1:0] == $past(st.strap))
    else $error("strap address not used");

  bcast_addr_a: assert property (st.sleep_cfg[BCAST_BIT] |=> i2c_target_addr == BCAST_ADDR)
    else $error("broadcast address not used");

  vref_code_a: assert property (sleep_rise && st.sleep_cfg[VREF_LSB +: 2] == 2'h0
                                |-> vref_tmr.load_ticks == TICKS_W'(7))
    else $error("reference charge interval wrong");

  incap_code_a: assert property (sleep_rise && st.shutdown_config[INCAP_LSB +: 2] == 2'h3
                                 |-> incap_tmr.load_ticks == TICKS_W'(100))
    else $error("input charge interval wrong");

  immed_off_a: assert property (st.reg_state == PRS_REG_ON && pin_fall
                                && policy == POL_IMMEDIATE |=> !core_regulator_en)
    else $error("regulator not switched off at once");

  timeout_off_a: assert property (st.reg_state == PRS_REG_HOLD && ka_done && !shutdown_pin_n
                                  && policy == POL_TIMED |=> st.reg_state == PRS_REG_OFF)
    else $error("regulator not forced off at timeout");

  hold_on_a: assert property (st.reg_state == PRS_REG_HOLD && policy == POL_UNTIL_DONE
                              && !shutdown_done && !shutdown_pin_n |=> core_regulator_en)
    else $error("regulator dropped before clean shutdown");

  ka_code_a: assert property (ka_tmr.start && st.shutdown_config[KA_LSB +: 2] == 2'h0
                              |-> ka_tmr.load_ticks == TICKS_W'(60))
    else $error("keep-alive interval wrong");

  supply_sel_a: assert property (wr_sleep && !st.srst_pend
                                 |=> ##1 analog_supply_source_sel == $past(reg_wdata[SUPPLY_BIT], 2))
    else $error("supply select not applied");

  fall_hold_a: assert property (st.reg_state == PRS_REG_ON && pin_fall
                                && policy != POL_IMMEDIATE |=> shutdown_request && core_regulator_en)
    else $error("shutdown edge did not start hold");

endmodule
`default_nettype wire

// ==== prs_ctrl_bench.sv ====
// bench: page, soft reset, sleep, address and shutdown policies
// assumes prs_ctrl with a short tick of 4 clocks
`timescale 1ns/100ps
`default_nettype none
module prs_ctrl_bench;
  import prs_pkg::*;
  logic       sys_clk, rst, wr, rd, rvalid, pin_n, done;
  logic       sleep_a, sup, vfc, ifc, reg_en, sreq;
  logic [7:0] addr, wdata, rdata, page, v;
  logic [1:0] strap;
  logic [6:0] taddr;
  logic [7:0] exp_q[$];
  int         n_fail, cmp_count, cnt, cnt2;

  // ****************************************************************
  // design, host and clock
  // ****************************************************************
  prs_ctrl #(.TICK_CYCLES(4)) dut (.sys_clk(sys_clk), .rst(rst), .reg_wr_en(wr),
    .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rd_valid(rvalid), .page_select(page), .addr_strap_pin(strap),
    .i2c_target_addr(taddr), .sleep_active(sleep_a), .analog_supply_source_sel(sup),
    .vref_fast_charge(vfc), .input_cap_fast_charge(ifc), .shutdown_pin_n(pin_n),
    .shutdown_done(done), .core_regulator_en(reg_en), .shutdown_request(sreq));
  prs_host_model host (.sys_clk(sys_clk), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wdata));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // counts cycles with each fast charge high over n cycles
  task automatic count_charge(input int n);
    cnt = 0;
    cnt2 = 0;
    repeat (n) begin
      @(negedge sys_clk);
      cnt += int'(vfc);
      cnt2 += int'(ifc);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // read data checked against the oldest note
  always @(posedge sys_clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("rd_extra", 8'h00, 8'h01);
      end else begin
        chk("rdata", exp_q.pop_front(), rdata);
      end
    end
  end

  // watchdog well past the expected run
  initial begin
    #80000;
    n_fail++;
    report_and_stop();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    void'($urandom(88437));
    rst = 1'b1;
    pin_n = 1'b1;
    done = 1'b0;
    strap = 2'($urandom_range(3, 1));  // nonzero, so strap and broadcast addresses differ
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd_exp(OFF_PAGE, 8'h00);
    rd_exp(OFF_SRST, 8'h00);
    rd_exp(OFF_SLEEP, 8'h00);
    rd_exp(OFF_SHDN, 8'h05);
    v = 8'($urandom_range(255, 1));
    host.acc(1'b1, OFF_PAGE, v);
    rd_exp(OFF_PAGE, v);
    rd_exp(OFF_SHDN, 8'h00);
    host.acc(1'b1, OFF_PAGE, PAGE_ZERO);
    wait_n(1);
    chk("page", PAGE_ZERO, page);
    host.acc(1'b1, OFF_SLEEP, 8'h01);
    count_charge(60);
    chk("vref_len", 8'h01, 8'(cnt >= 24 && cnt <= 34));
    chk("incap_len", 8'h01, 8'(cnt2 >= 16 && cnt2 <= 26));
    host.acc(1'b1, OFF_SLEEP, 8'hFF);
    rd_exp(OFF_SLEEP, 8'hFD);
    wait_n(2);
    chk("taddr", 8'(BCAST_ADDR), 8'(taddr));
    chk("supply", 8'h01, 8'(sup));
    chk("sleep", 8'h00, 8'(sleep_a));
    host.acc(1'b1, OFF_SLEEP, 8'h00);
    wait_n(3);
    chk("taddr", 8'({STRAP_BASE_ADDR[6:2], strap}), 8'(taddr));
    chk("sleep", 8'h01, 8'(sleep_a));
    host.acc(1'b1, OFF_SHDN, 8'h3A);
    host.acc(1'b1, OFF_SRST, 8'h01);
    wait_n(3);
    rd_exp(OFF_SHDN, 8'h05);
    rd_exp(OFF_SRST, 8'h00);
    // longest charge codes: reference 200 ticks, input 100 ticks
    host.acc(1'b1, OFF_SHDN, 8'h35);
    host.acc(1'b1, OFF_SLEEP, 8'h19);
    count_charge(820);
    chk("vref_len3", 8'h01, 8'(cnt >= 790 && cnt <= 806));
    chk("incap_len3", 8'h01, 8'(cnt2 >= 390 && cnt2 <= 406));
    host.acc(1'b1, OFF_SHDN, 8'h01);
    @(posedge sys_clk);
    pin_n <= 1'b0;
    wait_n(3);
    chk("reg_en", 8'h00, 8'(reg_en));
    @(posedge sys_clk);
    pin_n <= 1'b1;
    host.acc(1'b1, OFF_SHDN, 8'h04);
    @(posedge sys_clk);
    pin_n <= 1'b0;
    wait_n(3);
    chk("sreq", 8'h01, 8'(sreq));
    cnt = 0;
    while (reg_en === 1'b1 && cnt < 300) begin
      @(negedge sys_clk);
      cnt++;
    end
    chk("ka_len", 8'h01, 8'(cnt >= 232 && cnt <= 248));
    @(posedge sys_clk);
    pin_n <= 1'b1;
    host.acc(1'b1, OFF_SHDN, 8'h0B);
    @(posedge sys_clk);
    pin_n <= 1'b0;
    wait_n(100);
    chk("reg_en", 8'h01, 8'(reg_en));
    @(posedge sys_clk);
    done <= 1'b1;
    wait_n(3);
    chk("reg_en", 8'h00, 8'(reg_en));
    @(posedge sys_clk);
    pin_n <= 1'b1;
    done <= 1'b0;
    wait_n(3);
    chk("reg_en", 8'h01, 8'(reg_en));
    chk("rd_pending", 8'h00, 8'(exp_q.size()));
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== prs_host_model.sv ====
// host model: byte-wide register master facing the control block
// assumes strobes launched just after sys_clk rises, one cycle long
`timescale 1ns/100ps
`default_nettype none
module prs_host_model (
  input  wire logic       sys_clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  // ****************************************************************
  // bus idle values and one access per call
  // ****************************************************************
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'hFF;
    reg_wdata = 8'hFF;
  end

  // one access, held through the edge that takes it
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_en <= wr;
    reg_rd_en <= ~wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;  // released bus shows no stale value
    reg_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== prs_interval_timer.sv ====
// tick-counting interval timer: busy for load_ticks ticks after start
// assumes tick is a one-cycle enable pulse from the owner's divider
`timescale 1ns/100ps
`default_nettype none
module prs_interval_timer
  import prs_pkg::*;
(
  input wire logic   sys_clk,
  input wire logic   rst,
  prs_timer_if.timer tmr
);

  typedef struct packed {
    logic [TICKS_W-1:0] remaining;
    logic               busy;
  } prs_timer_state_type;

  prs_timer_state_type state;
  prs_timer_state_type next_state;

  // ****************************************************************
  // countdown
  // ****************************************************************
  // clear beats start, start beats counting
  always_comb begin
    next_state = state;
    if (tmr.clear) begin
      next_state.remaining = '0;
      next_state.busy      = 1'b0;
    end else if (tmr.start) begin
      next_state.remaining = tmr.load_ticks;
      next_state.busy      = (tmr.load_ticks != '0);
    end else if (state.busy && tmr.tick) begin
      if (state.remaining <= TICKS_W'(1)) begin
        next_state.remaining = '0;
        next_state.busy      = 1'b0;
      end else begin
        next_state.remaining = state.remaining - TICKS_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tmr.busy = state.busy;

  // ****************************************************************
  // checks
  // ****************************************************************
  start_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    tmr.start && !tmr.clear && tmr.load_ticks != '0 |=> state.busy
      && state.remaining == $past(tmr.load_ticks))
    else $error("timer did not load its interval");

  tick_step_a: assert property (@(posedge sys_clk) disable iff (rst)
    state.busy && tmr.tick && !tmr.start && !tmr.clear && state.remaining > TICKS_W'(1)
      |=> state.busy && state.remaining == $past(state.remaining) - TICKS_W'(1))
    else $error("timer did not count one tick");

endmodule
`default_nettype wire

// ==== prs_pkg.sv ====
// constants, field layout and types of the page, reset, sleep and shutdown control block
// assumes a single 250 MHz device clock and a byte-wide register port from the control-bus front end
package prs_pkg;

  // ****************************************************************
  // register offsets and field positions
  // ****************************************************************
  localparam logic [7:0] OFF_PAGE   = 8'h00;
  localparam logic [7:0] OFF_SRST   = 8'h01;
  localparam logic [7:0] OFF_SLEEP  = 8'h02;
  localparam logic [7:0] OFF_SHDN   = 8'h05;
  localparam logic [7:0] PAGE_ZERO  = 8'h00;

  localparam int SRST_BIT    = 0;
  localparam int SLEEP_BIT   = 0;
  localparam int BCAST_BIT   = 2;
  localparam int VREF_LSB    = 3;
  localparam int SUPPLY_BIT  = 7;
  localparam int KA_LSB      = 0;
  localparam int POLICY_LSB  = 2;
  localparam int INCAP_LSB   = 4;

  // ****************************************************************
  // reset values and writable bits
  // ****************************************************************
  localparam logic [7:0] RST_PAGE    = 8'h00;
  localparam logic [7:0] RST_SLEEP   = 8'h00;
  localparam logic [7:0] RST_SHDN    = 8'h05;
  localparam logic [7:0] SLEEP_WMASK = 8'hFD;
  localparam logic [7:0] SHDN_WMASK  = 8'h3F;

  // ****************************************************************
  // control-bus target addresses
  // ****************************************************************
  localparam logic [6:0] BCAST_ADDR      = 7'h4C;
  localparam logic [6:0] STRAP_BASE_ADDR = 7'h4C;

  // ****************************************************************
  // shutdown policy codes and regulator states
  // ****************************************************************
  localparam logic [1:0] POL_IMMEDIATE  = 2'h0;
  localparam logic [1:0] POL_TIMED      = 2'h1;
  localparam logic [1:0] POL_UNTIL_DONE = 2'h2;

  typedef enum logic [1:0] {
    PRS_REG_ON,
    PRS_REG_HOLD,
    PRS_REG_OFF
  } prs_reg_state_type;

  // ****************************************************************
  // timing: a 0.5 ms tick drives all interval timers
  // ****************************************************************
  localparam int CLK_MHZ          = 250;
  localparam int TICK_US          = 500;
  localparam int TICK_CYCLES_DEF  = TICK_US * CLK_MHZ;
  localparam int TICK_CNT_W       = 17;
  localparam int TICKS_W          = 8;

  localparam int VREF_US_0  = 3500;
  localparam int VREF_US_1  = 10000;
  localparam int VREF_US_2  = 50000;
  localparam int VREF_US_3  = 100000;
  localparam int INCAP_US_0 = 2500;
  localparam int INCAP_US_1 = 12500;
  localparam int INCAP_US_2 = 25000;
  localparam int INCAP_US_3 = 50000;
  localparam int KA_US_0    = 30000;
  localparam int KA_US_1    = 25000;
  localparam int KA_US_2    = 10000;
  localparam int KA_US_3    = 5000;

  // microseconds to whole ticks, at least one
  function automatic logic [TICKS_W-1:0] us_to_ticks(input int us);
    int t;
    t = us / TICK_US;
    if (t < 1) begin
      t = 1;
    end
    return TICKS_W'(t);
  endfunction

  // pick one of four durations by a two-bit code
  function automatic logic [TICKS_W-1:0] pick_ticks(input logic [1:0] code, input int us0,
                                                    input int us1, input int us2, input int us3);
    logic [TICKS_W-1:0] r;
    r = us_to_ticks(us0);
    case (code)
      2'h1: r = us_to_ticks(us1);
      2'h2: r = us_to_ticks(us2);
      2'h3: r = us_to_ticks(us3);
      default: r = us_to_ticks(us0);
    endcase
    return r;
  endfunction

endpackage

// ==== prs_timer_if.sv ====
// carrier between the control block and one of its interval timers
// assumes both ends run on sys_clk
`timescale 1ns/100ps
`default_nettype none
interface prs_timer_if;
  import prs_pkg::*;
  logic               start;
  logic               clear;
  logic               tick;
  logic [TICKS_W-1:0] load_ticks;
  logic               busy;

  modport ctrl (output start, output clear, output tick, output load_ticks, input busy);
  modport timer (input start, input clear, input tick, input load_ticks, output busy);
endinterface
`default_nettype wire
